/* port_a_defines.svh */
// register offsets, reset values and widths of the general-purpose port
`ifndef PORT_A_DEFINES_SVH
`define PORT_A_DEFINES_SVH

`define PA_ADDR_W 3
`define PA_OFS_PIN_VALUE 3'h0
`define PA_OFS_LATCH 3'h1
`define PA_OFS_DIRECTION 3'h2
`define PA_OFS_ANALOG_SEL 3'h3
`define PA_OFS_BIT_OP 3'h4

`define PA_RST_LATCH 8'h00
`define PA_RST_DIRECTION 8'hff
`define PA_RST_ANALOG_SEL 6'h3f
`define PA_ANALOG_W 6

`define PA_BITOP_SET_POS 7
`define PA_BITOP_IDX_MSB 2
`define PA_BITOP_IDX_LSB 0

`define PA_PRIO_N 5

`endif

/* port_a_pkg.sv */
// types shared by the general-purpose port
package port_a_pkg;

  // configuration-word functions and package strap
  typedef struct packed {
    logic regulator_cap_function_pin0;
    logic regulator_cap_function_pin5;
    logic regulator_cap_function_pin6;
    logic osc_out_en;
    logic clk_out_en;
    logic osc_in_en;
    logic small_pkg;
  } cfg_t;

  // on-chip peripheral outputs that may claim a pin
  typedef struct packed {
    logic [7:0] lcd_en;
    logic [7:0] lcd_val;
    logic seg15_en;
    logic seg15_val;
    logic sr_q_en;
    logic sr_q;
    logic sr_nq_en;
    logic sr_nq;
    logic cmp1_en;
    logic cmp1_out;
    logic cmp2_en;
    logic cmp2_out;
    logic capture_compare_five_en;
    logic capture_compare_five_val;
    logic dac_en;
    logic clk_out_val;
  } periph_t;

  // register-side request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] direction;
    logic [5:0] analog_sel;
    logic [7:0] rdata;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
  } state_t;

endpackage : port_a_pkg

/* port_a_gpio.sv */
// eight-pin general-purpose port with analog select and output priority mux
`timescale 1ns/10ps
`default_nettype none
`include "port_a_defines.svh"

module port_a_gpio #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire port_a_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  // configuration and peripheral functions
  input wire port_a_pkg::cfg_t cfg,
  input wire port_a_pkg::periph_t periph,
  // pins
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe
);

  if (PORT_W != 8) begin : g_bad_width
    $error("port_a_gpio serves exactly eight pins");
  end

  port_a_pkg::state_t st_q;
  port_a_pkg::state_t st_d;

  // per-pin priority table, index 4 highest; rel means the function owns
  // the pin but does not drive it digitally
  logic [`PA_PRIO_N-1:0] fen [8];
  logic [`PA_PRIO_N-1:0] fval [8];
  logic [`PA_PRIO_N-1:0] frel [8];
  logic [7:0] ansel_full;
  logic [7:0] pin_read;

  // pins 7 and 6 have no analog select, so they stay digital
  assign ansel_full = {2'h0, st_q.analog_sel};
  assign pin_read = pad_in & ~ansel_full;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      fen[i] = '0;
      fval[i] = '0;
      frel[i] = '0;
    end
    fen[0] = {cfg.regulator_cap_function_pin0, periph.lcd_en[0], periph.sr_nq_en, periph.cmp2_en, 1'b0};
    fval[0] = {1'b0, periph.lcd_val[0], periph.sr_nq, periph.cmp2_out, 1'b0};
    frel[0] = 5'h10;
    fen[1] = {periph.lcd_en[1], 4'h0};
    fval[1] = {periph.lcd_val[1], 4'h0};
    fen[2] = {periph.lcd_en[2], periph.dac_en, 3'h0};
    fval[2] = {periph.lcd_val[2], 4'h0};
    frel[2] = 5'h08;
    fen[3] = {periph.lcd_en[3], periph.seg15_en & cfg.small_pkg, 3'h0};
    fval[3] = {periph.lcd_val[3], periph.seg15_val, 3'h0};
    fen[4] = {periph.lcd_en[4], periph.sr_q_en, periph.cmp1_en,
              periph.capture_compare_five_en & cfg.small_pkg, 1'b0};
    fval[4] = {periph.lcd_val[4], periph.sr_q, periph.cmp1_out, periph.capture_compare_five_val, 1'b0};
    fen[5] = {cfg.regulator_cap_function_pin5, periph.lcd_en[5], periph.sr_nq_en, periph.cmp2_en, 1'b0};
    fval[5] = {1'b0, periph.lcd_val[5], periph.sr_nq, periph.cmp2_out, 1'b0};
    frel[5] = 5'h10;
    fen[6] = {cfg.regulator_cap_function_pin6, cfg.osc_out_en, cfg.clk_out_en, periph.lcd_en[6], 1'b0};
    fval[6] = {2'h0, periph.clk_out_val, periph.lcd_val[6], 1'b0};
    frel[6] = 5'h18;
    fen[7] = {cfg.osc_in_en, periph.lcd_en[7], 3'h0};
    fval[7] = {1'b0, periph.lcd_val[7], 3'h0};
    frel[7] = 5'h10;
  end

  always_comb begin
    logic drive;
    logic val;
    logic [7:0] rmw;
    drive = 1'b0;
    val = 1'b0;
    rmw = '0;
    st_d = st_q;
    st_d.rdata = '0;

    if (bus.wr) begin
      unique case (bus.addr)
        `PA_OFS_PIN_VALUE, `PA_OFS_LATCH: st_d.latch = bus.wdata;
        `PA_OFS_DIRECTION: st_d.direction = bus.wdata;
        `PA_OFS_ANALOG_SEL: st_d.analog_sel = bus.wdata[`PA_ANALOG_W-1:0];
        `PA_OFS_BIT_OP: begin
          // present pin states feed the store, so analog pins read back 0
          rmw = pin_read;
          rmw[bus.wdata[`PA_BITOP_IDX_MSB:`PA_BITOP_IDX_LSB]] =
            bus.wdata[`PA_BITOP_SET_POS];
          st_d.latch = rmw;
        end
        default: ;
      endcase
    end

    if (bus.rd) begin
      unique case (bus.addr)
        `PA_OFS_PIN_VALUE: st_d.rdata = pin_read;
        `PA_OFS_LATCH: st_d.rdata = st_q.latch;
        `PA_OFS_DIRECTION: st_d.rdata = st_q.direction;
        `PA_OFS_ANALOG_SEL: st_d.rdata = ansel_full;
        default: st_d.rdata = '0;
      endcase
    end

    for (int i = 0; i < 8; i++) begin
      // walk lowest to highest so the highest enabled function wins
      drive = 1'b1;
      val = st_q.latch[i];
      for (int k = 0; k < `PA_PRIO_N; k++) begin
        if (fen[i][k]) begin
          drive = ~frel[i][k];
          val = fval[i][k];
        end
      end
      st_d.pad_out[i] = val;
      // analog select plays no part here, direction and released functions gate the driver
      st_d.pad_oe[i] = drive & ~st_q.direction[i];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q.latch <= `PA_RST_LATCH;
      st_q.direction <= `PA_RST_DIRECTION;
      st_q.analog_sel <= `PA_RST_ANALOG_SEL;
      st_q.rdata <= '0;
      st_q.pad_out <= '0;
      st_q.pad_oe <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign pad_out = st_q.pad_out;
  assign pad_oe = st_q.pad_oe;

  a_pin_read_value: assert property (@(posedge clk) disable iff (!nrst)
    (bus.rd && bus.addr == `PA_OFS_PIN_VALUE) |=>
      rdata == ($past(pad_in) & ~{2'h0, $past(st_q.analog_sel)}))
    else $error("pin value read mismatch");

  a_analog_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
    (bus.rd && bus.addr == `PA_OFS_PIN_VALUE && st_q.analog_sel[0]) |=> !rdata[0])
    else $error("analog pin read as one");

  a_ansel_upper_zero: assert property (@(posedge clk) disable iff (!nrst)
    (bus.rd && bus.addr == `PA_OFS_ANALOG_SEL) |=> rdata[7:6] == 2'h0)
    else $error("unimplemented analog bits not zero");

  a_input_no_drive: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (pad_oe & $past(st_q.direction)) == 8'h00)
    else $error("input pin driven");

  a_latch_on_pin1: assert property (@(posedge clk) disable iff (!nrst)
    (!st_q.direction[1] && !periph.lcd_en[1]) |=>
      pad_oe[1] && pad_out[1] == $past(st_q.latch[1]))
    else $error("pin1 not driving latch");

  a_analog_still_drives: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.analog_sel[2] && !st_q.direction[2] && !periph.lcd_en[2] && !periph.dac_en)
      |=> pad_oe[2])
    else $error("analog select gated output");

  a_port_write_latch: assert property (@(posedge clk) disable iff (!nrst)
    (bus.wr && bus.addr == `PA_OFS_PIN_VALUE) |=> st_q.latch == $past(bus.wdata))
    else $error("port write lost");

  a_bitop_rmw: assert property (@(posedge clk) disable iff (!nrst)
    (bus.wr && bus.addr == `PA_OFS_BIT_OP && bus.wdata[2:0] != 3'h5) |=>
      st_q.latch[5] == $past(pad_in[5] & ~st_q.analog_sel[5]))
    else $error("read-modify-write did not sample pins");

  a_pin0_regcap: assert property (@(posedge clk) disable iff (!nrst)
    cfg.regulator_cap_function_pin0 |=> !pad_oe[0])
    else $error("pin0 driven under regulator function");

  a_pin4_order: assert property (@(posedge clk) disable iff (!nrst)
    (!periph.lcd_en[4] && periph.sr_q_en && periph.cmp1_en) |=>
      pad_out[4] == $past(periph.sr_q))
    else $error("pin4 priority wrong");

  a_pin6_clock_output_function: assert property (@(posedge clk) disable iff (!nrst)
    (!cfg.regulator_cap_function_pin6 && !cfg.osc_out_en && cfg.clk_out_en && periph.lcd_en[6]) |=>
      pad_out[6] == $past(periph.clk_out_val))
    else $error("pin6 clock output lost");

  a_pin7_oscin: assert property (@(posedge clk) disable iff (!nrst)
    cfg.osc_in_en |=> !pad_oe[7])
    else $error("pin7 driven under oscillator input");

  a_pin3_small: assert property (@(posedge clk) disable iff (!nrst)
    (!periph.lcd_en[3] && periph.seg15_en && !cfg.small_pkg) |=>
      pad_out[3] == $past(st_q.latch[3]))
    else $error("pin3 segment on large package");

endmodule : port_a_gpio
`default_nettype wire

/* board_model.sv */
// board circuitry that resolves each port pin
`timescale 1ns/10ps
`default_nettype none
module board_model (
  // device side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  // board level on released pins
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  // released pins follow the board, never a held value
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule : board_model
`default_nettype wire

/* port_a_gpio_with_analog_select_tb_top.sv */
// self-checking bench for the general-purpose port
`timescale 1ns/10ps
`default_nettype none
module port_a_gpio_with_analog_select_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  port_a_pkg::bus_req_t bus = '0;
  port_a_pkg::cfg_t cfg = '0;
  port_a_pkg::periph_t periph = '0;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] pad_in, pad_out, pad_oe, rdata;
  int failures = 0;
  int samples_checked = 0;
  integer seed = 32'h358ed9bc;
  logic [7:0] m_latch = 8'h00;
  logic [7:0] m_dir = 8'hff;
  logic [5:0] m_ana = 6'h3f;
  logic e_own, e_val;
  logic [31:0] r;

  always #20 clk = ~clk;

  port_a_gpio dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .cfg(cfg),
    .periph(periph), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  board_model board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
    .pad_in(pad_in));

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // one bus cycle, then an idle cycle; reads compared in the cycle after
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] wd);
    logic [7:0] pins, exp;
    @(posedge clk);
    bus <= '{wr: wr, rd: ~wr, addr: a, wdata: wd};
    @(negedge clk);
    pins = pad_in & ~{2'h0, m_ana};
    case (a)
      3'h0: exp = pins;
      3'h1: exp = m_latch;
      3'h2: exp = m_dir;
      3'h3: exp = {2'h0, m_ana};
      default: exp = 8'h00;
    endcase
    if (wr) begin
      case (a)
        3'h0, 3'h1: m_latch = wd;
        3'h2: m_dir = wd;
        3'h3: m_ana = wd[5:0];
        3'h4: begin
          m_latch = pins;
          m_latch[wd[2:0]] = wd[7];
        end
        default: ;
      endcase
    end
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    if (!wr) cmp("rdata", exp, rdata);
  endtask : access

  task automatic put(input logic en, input logic own, input logic v);
    if (en) begin
      e_own = own;
      e_val = v;
    end
  endtask : put

  // claims applied lowest priority first so the highest one is left standing
  task automatic chk_pins();
    logic [7:0] eo, ev;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      e_own = 1'b0;
      e_val = m_latch[i];
      case (i)
        0, 5: begin
          put(periph.cmp2_en, 1'b0, periph.cmp2_out);
          put(periph.sr_nq_en, 1'b0, periph.sr_nq);
        end
        2: put(periph.dac_en, 1'b1, 1'b0);
        3: put(periph.seg15_en & cfg.small_pkg, 1'b0, periph.seg15_val);
        4: begin
          put(periph.capture_compare_five_en & cfg.small_pkg, 1'b0, periph.capture_compare_five_val);
          put(periph.cmp1_en, 1'b0, periph.cmp1_out);
          put(periph.sr_q_en, 1'b0, periph.sr_q);
        end
        default: ;
      endcase
      put(periph.lcd_en[i], 1'b0, periph.lcd_val[i]);
      case (i)
        0: put(cfg.regulator_cap_function_pin0, 1'b1, 1'b0);
        5: put(cfg.regulator_cap_function_pin5, 1'b1, 1'b0);
        6: begin
          put(cfg.clk_out_en, 1'b0, periph.clk_out_val);
          put(cfg.osc_out_en, 1'b1, 1'b0);
          put(cfg.regulator_cap_function_pin6, 1'b1, 1'b0);
        end
        7: put(cfg.osc_in_en, 1'b1, 1'b0);
        default: ;
      endcase
      eo[i] = ~e_own & ~m_dir[i];
      ev[i] = e_val;
    end
    cmp("pad_oe", eo, pad_oe);
    cmp("pad_out", ev & eo, pad_out & eo);
  endtask : chk_pins

  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // about 2100 cycles expected; generous margin
  initial begin
    #1ms;
    failures++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    chk_pins();
    access(1'b0, 3'h2, 8'h00);
    access(1'b0, 3'h3, 8'h00);
    access(1'b0, 3'h0, 8'h00);
    access(1'b0, 3'h6, 8'h00);
    access(1'b1, 3'h3, 8'hff);
    access(1'b0, 3'h3, 8'h00);
    $display("test reset_defaults done");
    repeat (300) begin
      @(posedge clk);
      r = $random(seed) & $random(seed);
      periph <= r[29:0];
      r = $random(seed) & $random(seed) & $random(seed);
      cfg <= r[6:0];
      r = $random(seed);
      ext_val <= r[31:24];
      access(1'b1, r[2:0], r[15:8]);
      if (r[18:16] == 3'h4) r[18:16] = 3'h7;
      access(1'b0, r[18:16], 8'h00);
      chk_pins();
    end
    $display("test random_traffic done");
    results();
  end
endmodule : port_a_gpio_with_analog_select_tb_top
`default_nettype wire
